//--- hw/irs_defines.svh
`ifndef IRS_DEFINES_SVH
`define IRS_DEFINES_SVH

// Register indexes; byte address is four times the index
`define IRS_IDX_ROUTE0      19'h40098
`define IRS_IDX_ROUTE2      19'h4009A
`define IRS_IDX_PULLUP      19'h4009C
`define IRS_IDX_ODSEL       19'h4009D
`define IRS_IDX_STATUS      19'h4009E

// Reset values
`define IRS_RST_ROUTE0      8'h00
`define IRS_RST_ROUTE2      8'h00
`define IRS_RST_PULLUP      8'h00
`define IRS_RST_ODSEL       1'h0

// Writable bits of the first route register
`define IRS_ROUTE0_MASK     8'h55

// Field positions, first route register
`define IRS_TA_BIT          0
`define IRS_S3_BIT          2
`define IRS_S4_BIT          4
`define IRS_TB_BIT          6

// Field positions, second route register (low bit of each pair)
`define IRS_G0_LO           0
`define IRS_G0Q_LO          2
`define IRS_G1_LO           4
`define IRS_G1Q_LO          6

// Status fields
`define IRS_ST_G0_BAD       6
`define IRS_ST_G1_BAD       7

`endif

//--- hw/irs_pkg.sv
package irs_pkg;

    // Group 0 eight-input route codes
    typedef enum logic [1:0] {
        IRS_G0_BAD0 = 2'h0,
        IRS_G0_P1   = 2'h1,
        IRS_G0_P5   = 2'h2,
        IRS_G0_BAD3 = 2'h3
    } irs_g0_route_t;

    // Group 1 eight-input route codes
    typedef enum logic [1:0] {
        IRS_G1_P78  = 2'h0,
        IRS_G1_P1   = 2'h1,
        IRS_G1_P4   = 2'h2,
        IRS_G1_BAD  = 2'h3
    } irs_g1_route_t;

    // Two-phase counter route codes
    typedef enum logic [1:0] {
        IRS_Q_P8_I1 = 2'h0,
        IRS_Q_P7_I0 = 2'h1,
        IRS_Q_P3_I1 = 2'h2,
        IRS_Q_P3_I0 = 2'h3
    } irs_quad_route_t;

endpackage

//--- hw/irs_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for a bus of independent pin levels
module irs_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

`default_nettype wire

//--- hw/irs_top.sv
// How it works
// R1 - Timer A feedback and count inputs come from port 3 when the timer A route bit is 0, else from port 7 and pins P8_0, P8_1.
// R2 - The serial channel 3 route bit picks clock, receive and clear-to-send from P4_1, P4_2, P4_0 or from P7_7, P8_0, P8_1.
// R3 - The serial channel 4 route bit picks clock, receive and clear-to-send from P9_5, P9_7, P9_4 or from P3_4, P3_5, P3_7.
// R4 - The timer B route bit maps the six timer B inputs to P6_0, P6_1, P6_2, P9_3, P9_4, P6_3 or to P1_4, P3_7, P9_7, P9_3, P9_4, P7_1.
// R5 - I/O group 0 inputs come from port 1 on code 01 and port 5 on code 10; codes 00 and 11 are prohibited.
// R6 - Group 0 two-phase inputs come from P8_0/P8_1/P8_3, P7_6/P7_7/P8_2, P3_0/P3_1/P8_3 or P3_0/P3_1/P8_2 for codes 00 to 11.
// R7 - I/O group 1 inputs come from P7_3..P7_7, P8_1, P7_0, P7_1 on 00, port 1 on 01, port 4 on 10; code 11 is prohibited.
// R8 - Group 1 two-phase inputs use the same pins as group 0, the index from interrupt 1 on even codes and interrupt 0 on odd codes.
// R9 - The second route register is eight bits, resets to zero and is fully readable and writable.
// R10 - Each pull-up enable bit covers four pins and applies only while those pins are inputs.
// R11 - The port 1 output-mode bit set to 1 turns off the high-side driver, giving pseudo open drain; 0 gives push-pull.
// R12 - Each peripheral input sees only its selected pin, and a route change acts on the next clock.
`timescale 1ns/100ps
`default_nettype none
`include "irs_defines.svh"

module irs_top
    import irs_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Package pin levels (asynchronous)
    input  wire logic [7:0]  p1_pin,
    input  wire logic [7:0]  p3_pin,
    input  wire logic [7:0]  p4_pin,
    input  wire logic [7:0]  p5_pin,
    input  wire logic [7:0]  p6_pin,
    input  wire logic [7:0]  p7_pin,
    input  wire logic [7:0]  p8_pin,
    input  wire logic [7:0]  p9_pin,
    // Port direction bits, 1 = output
    input  wire logic [7:0]  p1_dir,
    input  wire logic [7:0]  p3_dir,
    input  wire logic [7:0]  p4_dir,
    input  wire logic [7:0]  p5_dir,
    // Port 1 output data
    input  wire logic [7:0]  p1_out,
    // Pull-up enables per pin
    output logic      [7:0]  p1_pullup_en,
    output logic      [7:0]  p3_pullup_en,
    output logic      [7:0]  p4_pullup_en,
    output logic      [7:0]  p5_pullup_en,
    // Port 1 output driver enables
    output logic      [7:0]  p1_high_drive_en,
    output logic      [7:0]  p1_low_drive_en,
    // Timer inputs
    output logic      [7:0]  timer_a_in,
    output logic      [5:0]  timer_b_in,
    // Serial channel three
    output logic             serial3_clk_in,
    output logic             serial3_receive,
    output logic             serial3_clear_to_send,
    // Serial channel four
    output logic             serial4_clk_in,
    output logic             serial4_receive,
    output logic             serial4_clear_to_send,
    // I/O group 0
    output logic      [7:0]  io_group_zero_in,
    output logic             group0_phase_a_in,
    output logic             group0_phase_b_in,
    output logic             group0_index_in,
    // I/O group 1
    output logic      [7:0]  io_group_one_in,
    output logic             group1_phase_a_in,
    output logic             group1_phase_b_in,
    output logic             group1_index_in
);

    // Two-phase selection shared by both groups: {index, b, a}
    function automatic logic [2:0] quad_sel(
        input logic [1:0] code,
        input logic [7:0] p3,
        input logic [7:0] p7,
        input logic [7:0] p8
    );
        logic [2:0] r;
        r = 3'h0;
        unique case (irs_quad_route_t'(code))
            IRS_Q_P8_I1: r = {p8[3], p8[1], p8[0]};
            IRS_Q_P7_I0: r = {p8[2], p7[7], p7[6]};
            IRS_Q_P3_I1: r = {p8[3], p3[1], p3[0]};
            IRS_Q_P3_I0: r = {p8[2], p3[1], p3[0]};
        endcase
        return r;
    endfunction

    // Expand one enable bit per four pins to one per pin
    function automatic logic [7:0] nib_expand(input logic [1:0] en);
        return {{4{en[1]}}, {4{en[0]}}};
    endfunction

    // Synchronised pin levels
    logic [63:0] pins_s;
    logic [7:0]  s1, s3, s4, s5, s6, s7, s8, s9;

    irs_sync #(
        .W        (64)
    ) u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in ({p9_pin, p8_pin, p7_pin, p6_pin,
                    p5_pin, p4_pin, p3_pin, p1_pin}),
        .sync_out (pins_s)
    );

    assign {s9, s8, s7, s6, s5, s4, s3, s1} = pins_s;

    // Software registers
    logic [7:0] route0_q, route0_d;
    logic [7:0] route2_q, route2_d;
    logic [7:0] pullup_q, pullup_d;
    logic       odsel_q,  odsel_d;
    logic [7:0] status_q;

    // Bus decode in the address phase
    logic        acc_valid;
    logic [18:0] acc_idx;
    logic        acc_in_map;
    logic        wr_pend_q;
    logic [18:0] wr_idx_q;
    logic        wr_now;

    assign acc_valid  = hsel & hready & htrans[1];
    assign acc_idx    = haddr[20:2];
    assign acc_in_map = (haddr[31:21] == 11'h000) & (haddr[1:0] == 2'h0);
    assign wr_now     = wr_pend_q & hready;

    // Write pending into the next data phase
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 19'h00000;
        end else if (hready) begin
            wr_pend_q <= acc_valid & hwrite & acc_in_map;
            wr_idx_q  <= acc_idx;
        end
    end

    // Next register values, also used to forward a write to a read
    assign route0_d = (wr_now && wr_idx_q == `IRS_IDX_ROUTE0)
                    ? (hwdata[7:0] & `IRS_ROUTE0_MASK) : route0_q;
    assign route2_d = (wr_now && wr_idx_q == `IRS_IDX_ROUTE2)
                    ? hwdata[7:0] : route2_q; // R9
    assign pullup_d = (wr_now && wr_idx_q == `IRS_IDX_PULLUP)
                    ? hwdata[7:0] : pullup_q;
    assign odsel_d  = (wr_now && wr_idx_q == `IRS_IDX_ODSEL)
                    ? hwdata[0] : odsel_q;

    // Register update on the data phase
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            route0_q <= `IRS_RST_ROUTE0;
            route2_q <= `IRS_RST_ROUTE2; // R9
            pullup_q <= `IRS_RST_PULLUP;
            odsel_q  <= `IRS_RST_ODSEL;
        end else begin
            route0_q <= route0_d;
            route2_q <= route2_d;
            pullup_q <= pullup_d;
            odsel_q  <= odsel_d;
        end
    end

    // Read mux over the forwarded values
    logic [7:0] rd_byte;

    assign rd_byte =
        !acc_in_map                     ? 8'h00 :
        (acc_idx == `IRS_IDX_ROUTE0)    ? route0_d :
        (acc_idx == `IRS_IDX_ROUTE2)    ? route2_d : // R9
        (acc_idx == `IRS_IDX_PULLUP)    ? pullup_d :
        (acc_idx == `IRS_IDX_ODSEL)     ? {7'h00, odsel_d} :
        (acc_idx == `IRS_IDX_STATUS)    ? status_q : 8'h00;

    // Read data captured for the data phase
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hrdata <= 32'h00000000;
        end else if (acc_valid && !hwrite) begin
            hrdata <= {24'h000000, rd_byte};
        end
    end

    // Zero-wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Route fields
    logic       ta_sel, s3_sel, s4_sel, tb_sel;
    logic [1:0] g0_code, g0q_code, g1_code, g1q_code;

    assign ta_sel   = route0_q[`IRS_TA_BIT];
    assign s3_sel   = route0_q[`IRS_S3_BIT];
    assign s4_sel   = route0_q[`IRS_S4_BIT];
    assign tb_sel   = route0_q[`IRS_TB_BIT];
    assign g0_code  = route2_q[`IRS_G0_LO +: 2];
    assign g0q_code = route2_q[`IRS_G0Q_LO +: 2];
    assign g1_code  = route2_q[`IRS_G1_LO +: 2];
    assign g1q_code = route2_q[`IRS_G1Q_LO +: 2];

    // Timer A: TIMER_A0_OUT_PIN, TA1OUT, TA1IN, TA2OUT, TA2IN, TA3OUT, TA4OUT, TA4IN
    logic [7:0] ta_d;
    assign ta_d = ta_sel
        ? {s8[1], s8[0], s7[6], s7[5], s7[4], s7[3], s7[2], s7[0]}
        : {s3[7], s3[6], s3[1], s3[5], s3[4], s3[3], s3[2], s3[0]}; // R1

    // Serial channels: {clock, receive, clear-to-send}
    logic [2:0] s3ch_d, s4ch_d;
    assign s3ch_d = s3_sel ? {s7[7], s8[0], s8[1]}
                           : {s4[1], s4[2], s4[0]}; // R2
    assign s4ch_d = s4_sel ? {s3[4], s3[5], s3[7]}
                           : {s9[5], s9[7], s9[4]}; // R3

    // Timer B inputs 5..0
    logic [5:0] tb_d;
    assign tb_d = tb_sel
        ? {s7[1], s9[4], s9[3], s9[7], s3[7], s1[4]}
        : {s6[3], s9[4], s9[3], s6[2], s6[1], s6[0]}; // R4

    // Group 0 eight inputs; prohibited codes give zeros
    logic [7:0] g0_d;
    logic       g0_bad;
    assign g0_bad = (g0_code == IRS_G0_BAD0) | (g0_code == IRS_G0_BAD3);
    assign g0_d   = (g0_code == IRS_G0_P1) ? s1 :
                    (g0_code == IRS_G0_P5) ? s5 : 8'h00; // R5

    // Group 1 eight inputs; prohibited code gives zeros
    logic [7:0] g1_d;
    logic       g1_bad;
    assign g1_bad = (g1_code == IRS_G1_BAD);
    assign g1_d   =
        (g1_code == IRS_G1_P78) ? {s7[1], s7[0], s8[1], s7[7],
                                   s7[6], s7[5], s7[4], s7[3]} :
        (g1_code == IRS_G1_P1)  ? s1 :
        (g1_code == IRS_G1_P4)  ? s4 : 8'h00; // R7

    // Two-phase counter inputs
    logic [2:0] g0q_d, g1q_d;
    assign g0q_d = quad_sel(g0q_code, s3, s7, s8); // R6
    assign g1q_d = quad_sel(g1q_code, s3, s7, s8); // R8

    // Registered peripheral inputs, one clock after a route change
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            timer_a_in <= 8'h00;
            timer_b_in <= 6'h00;
            {serial3_clk_in, serial3_receive, serial3_clear_to_send} <= 3'h0;
            {serial4_clk_in, serial4_receive, serial4_clear_to_send} <= 3'h0;
            io_group_zero_in <= 8'h00;
            io_group_one_in  <= 8'h00;
            {group0_index_in, group0_phase_b_in, group0_phase_a_in} <= 3'h0;
            {group1_index_in, group1_phase_b_in, group1_phase_a_in} <= 3'h0;
        end else begin
            timer_a_in <= ta_d; // R12
            timer_b_in <= tb_d;
            {serial3_clk_in, serial3_receive, serial3_clear_to_send} <= s3ch_d;
            {serial4_clk_in, serial4_receive, serial4_clear_to_send} <= s4ch_d;
            io_group_zero_in <= g0_d; // R12
            io_group_one_in  <= g1_d;
            {group0_index_in, group0_phase_b_in, group0_phase_a_in} <= g0q_d;
            {group1_index_in, group1_phase_b_in, group1_phase_a_in} <= g1q_d;
        end
    end

    // Status: routed two-phase levels and prohibited-code flags
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            status_q <= 8'h00;
        end else begin
            status_q <= {g1_bad, g0_bad, g1q_d, g0q_d};
        end
    end

    // Pull-ups only on pins set as input
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            p1_pullup_en <= 8'h00;
            p3_pullup_en <= 8'h00;
            p4_pullup_en <= 8'h00;
            p5_pullup_en <= 8'h00;
        end else begin
            p1_pullup_en <= nib_expand(pullup_q[1:0]) & ~p1_dir; // R10
            p3_pullup_en <= nib_expand(pullup_q[3:2]) & ~p3_dir; // R10
            p4_pullup_en <= nib_expand(pullup_q[5:4]) & ~p4_dir;
            p5_pullup_en <= nib_expand(pullup_q[7:6]) & ~p5_dir;
        end
    end

    // Port 1 drivers; high side off in pseudo open-drain mode
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            p1_high_drive_en <= 8'h00;
            p1_low_drive_en  <= 8'h00;
        end else begin
            p1_high_drive_en <= p1_dir & p1_out & {8{~odsel_q}}; // R11
            p1_low_drive_en  <= p1_dir & ~p1_out;
        end
    end

endmodule

`default_nettype wire

//--- sim/irs_pin_model.sv
`timescale 1ns/100ps
`default_nettype none

module irs_pin_model (
    // Port 1 drivers inside and outside the chip
    input  wire logic [7:0] high_en,
    input  wire logic [7:0] low_en,
    input  wire logic [7:0] ext_lvl,
    // Resolved pin levels
    output logic      [7:0] pin
);
    // High side wins, then low side, else the board level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin[i] = high_en[i] ? 1'b1 : (low_en[i] ? 1'b0 : ext_lvl[i]);
        end
    end
endmodule

`default_nettype wire

//--- sim/irs_props.sv
`timescale 1ns/100ps
`default_nettype none

module irs_props (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Bus and port controls
    input  wire logic [31:0] hrdata,
    input  wire logic [7:0]  p1_dir,
    input  wire logic [7:0]  p1_out,
    // Pin levels
    input  wire logic [7:0]  p3_pin,
    input  wire logic [7:0]  p4_pin,
    input  wire logic [7:0]  p7_pin,
    input  wire logic [7:0]  p8_pin,
    input  wire logic [7:0]  p9_pin,
    // Driver and routed outputs
    input  wire logic [7:0]  p1_pullup_en,
    input  wire logic [7:0]  p1_high_drive_en,
    input  wire logic [7:0]  p1_low_drive_en,
    input  wire logic [7:0]  timer_a_in,
    input  wire logic [5:0]  timer_b_in,
    input  wire logic        serial3_clear_to_send,
    input  wire logic        group0_index_in,
    input  wire logic        group1_index_in
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Edges since reset release, so three-deep history is clean
    logic [2:0] up_q;
    logic [2:0] up_d;
    logic       ok;
    assign up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
    assign ok   = (up_q >= 3'h4);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            up_q <= 3'h0;
        end else begin
            up_q <= up_d;
        end
    end

    ta0_route_a: assert property (ok |->
        timer_a_in[0] == $past(p3_pin[0], 3) ||
        timer_a_in[0] == $past(p7_pin[0], 3))
        else $error("timer A input from no candidate pin");
    s3_cts_a: assert property (ok |->
        serial3_clear_to_send == $past(p4_pin[0], 3) ||
        serial3_clear_to_send == $past(p8_pin[1], 3))
        else $error("serial 3 clear-to-send from no candidate pin");
    tb_fixed_a: assert property (ok |->
        timer_b_in[4:3] == $past(p9_pin[4:3], 3))
        else $error("timer B inputs 3 and 4 not from port 9");
    g0_index_a: assert property (ok |->
        group0_index_in == $past(p8_pin[3], 3) ||
        group0_index_in == $past(p8_pin[2], 3))
        else $error("group 0 index not from an interrupt pin");
    g1_index_a: assert property (ok |->
        group1_index_in == $past(p8_pin[3], 3) ||
        group1_index_in == $past(p8_pin[2], 3))
        else $error("group 1 index not from an interrupt pin");
    reg_width_a: assert property (hrdata[31:8] == 24'h000000)
        else $error("read data wider than eight bits");
    pullup_nib_a: assert property (ok |->
        p1_pullup_en[3:0] == 4'h0 ||
        p1_pullup_en[3:0] == ~$past(p1_dir[3:0]))
        else $error("pull-up not grouped by four input pins");
    od_low_a: assert property (ok |->
        p1_low_drive_en == ($past(p1_dir) & ~$past(p1_out)))
        else $error("low-side driver mismatch");
    od_high_a: assert property (ok |->
        (p1_high_drive_en & ~($past(p1_dir) & $past(p1_out))) == 8'h00)
        else $error("high-side driver on without output one");
endmodule

bind irs_top irs_props u_props (
    .mclk(mclk), .rst_n(rst_n), .hrdata(hrdata),
    .p1_dir(p1_dir), .p1_out(p1_out), .p3_pin(p3_pin),
    .p4_pin(p4_pin), .p7_pin(p7_pin), .p8_pin(p8_pin),
    .p9_pin(p9_pin), .p1_pullup_en(p1_pullup_en),
    .p1_high_drive_en(p1_high_drive_en),
    .p1_low_drive_en(p1_low_drive_en), .timer_a_in(timer_a_in),
    .timer_b_in(timer_b_in),
    .serial3_clear_to_send(serial3_clear_to_send),
    .group0_index_in(group0_index_in), .group1_index_in(group1_index_in)
);

`default_nettype wire

//--- sim/irs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "irs_defines.svh"

module irs_tb_top
    import irs_pkg::*;
;
    logic        mclk = 1'b0, rst_n = 1'b0, hsel = 1'b1, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_s;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        hready, hreadyout, hresp, rdy_s;
    logic [7:0]  p1_ext = 8'h0, p3 = 8'h0, p4 = 8'h0, p5 = 8'h0;
    logic [7:0]  p6 = 8'h0, p7 = 8'h0, p8 = 8'h0, p9 = 8'h0, p1_pin;
    logic [7:0]  d1 = 8'h0, d3 = 8'h0, d4 = 8'h0, d5 = 8'h0, p1_out = 8'h0;
    logic [7:0]  pu1, pu3, pu4, pu5, hi_en, lo_en, ta, io0, io1;
    logic [5:0]  tb;
    logic [2:0]  s3, s4, q0, q1;
    int          mismatches = 0, tests_run = 0;

    // Clock, single bus slave ready, answer sampled at the edge
    always #4 mclk = ~mclk;
    assign hready = hreadyout;
    always @(posedge mclk) begin
        rd_s <= hrdata;
        rdy_s <= hreadyout;
    end

    irs_pin_model u_pins (.high_en(hi_en), .low_en(lo_en), .ext_lvl(p1_ext),
        .pin(p1_pin));

    irs_top dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .p1_pin(p1_pin), .p3_pin(p3), .p4_pin(p4),
        .p5_pin(p5), .p6_pin(p6), .p7_pin(p7), .p8_pin(p8), .p9_pin(p9),
        .p1_dir(d1), .p3_dir(d3), .p4_dir(d4), .p5_dir(d5), .p1_out(p1_out),
        .p1_pullup_en(pu1), .p3_pullup_en(pu3), .p4_pullup_en(pu4),
        .p5_pullup_en(pu5), .p1_high_drive_en(hi_en),
        .p1_low_drive_en(lo_en), .timer_a_in(ta), .timer_b_in(tb),
        .serial3_clk_in(s3[2]), .serial3_receive(s3[1]),
        .serial3_clear_to_send(s3[0]), .serial4_clk_in(s4[2]),
        .serial4_receive(s4[1]), .serial4_clear_to_send(s4[0]),
        .io_group_zero_in(io0), .group0_phase_a_in(q0[2]),
        .group0_phase_b_in(q0[1]), .group0_index_in(q0[0]),
        .io_group_one_in(io1), .group1_phase_a_in(q1[2]),
        .group1_phase_b_in(q1[1]), .group1_index_in(q1[0]));

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk);
            #1;
        end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits for an edge with ready high, bounded
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (rdy_s !== 1'b1 && n < 50);
        if (rdy_s !== 1'b1) begin
            mismatches++;
            $display("Error at %0t: bus wait ran out", $time);
        end
    endtask

    task automatic bus(input logic wr, input logic [18:0] idx,
                       input logic [7:0] d, output logic [31:0] q);
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {11'h000, idx, 2'b00};
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        wait_rdy();
        q = rd_s;
    endtask

    task automatic wr(input logic [18:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rdchk(input logic [18:0] idx, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(q, {24'h000000, e});
    endtask

    // First route register: timer A, timer B, serial 3, serial 4
    function automatic logic [19:0] ex0(input logic [7:0] r);
        logic [7:0] a;
        logic [5:0] b;
        a = r[0] ? {p8[1], p8[0], p7[6], p7[5], p7[4], p7[3], p7[2], p7[0]}
                 : {p3[7], p3[6], p3[1], p3[5], p3[4], p3[3], p3[2], p3[0]};
        b = r[6] ? {p7[1], p9[4], p9[3], p9[7], p3[7], p1_pin[4]}
                 : {p6[3], p9[4], p9[3], p6[2], p6[1], p6[0]};
        return {a, b, r[2] ? {p7[7], p8[0], p8[1]} : {p4[1], p4[2], p4[0]},
                r[4] ? {p3[4], p3[5], p3[7]} : {p9[5], p9[7], p9[4]}};
    endfunction

    function automatic logic [2:0] qd(input logic [1:0] c);
        return c[1] ? {p3[0], p3[1], c[0] ? p8[2] : p8[3]}
                    : (c[0] ? {p7[6], p7[7], p8[2]} : {p8[0], p8[1], p8[3]});
    endfunction

    // Second route register, group 1 on its port 7/8 code
    function automatic logic [21:0] ex2(input logic [7:0] r);
        return {(r[1:0] == 2'h1) ? p1_pin : p5, qd(r[3:2]),
                {p7[1], p7[0], p8[1], p7[7], p7[6], p7[5], p7[4], p7[3]},
                qd(r[7:6])};
    endfunction

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #40000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        logic [7:0] m;
        logic [7:0] r0;
        logic [7:0] r2;
        tick(20);
        rst_n <= 1'b1;
        tick(1);
        rdchk(`IRS_IDX_ROUTE2, 8'h00);
        rdchk(`IRS_IDX_ROUTE0, 8'h00);
        rdchk(`IRS_IDX_PULLUP, 8'h00);
        wr(19'h40099, 8'hFF);
        rdchk(19'h40099, 8'h00);
        $display("test reset done");
        for (int v = 0; v < 2; v++) begin
            m = v ? 8'hFF : 8'h00;
            p1_ext <= 8'h3C ^ m;
            p3 <= 8'hA5 ^ m;
            p4 <= 8'h96 ^ m;
            p5 <= 8'h5A ^ m;
            p6 <= 8'hC9 ^ m;
            p7 <= 8'h6B ^ m;
            p8 <= 8'hD2 ^ m;
            p9 <= 8'h4E ^ m;
            for (int i = 0; i < 4; i++) begin
                r0 = 8'(32'h44115500 >> (8 * i));
                r2 = {i[1:0], 2'h0, i[1:0], i[0] ? 2'h1 : 2'h2};
                wr(`IRS_IDX_ROUTE0, r0);
                wr(`IRS_IDX_ROUTE2, r2);
                rdchk(`IRS_IDX_ROUTE2, r2);
                tick(4);
                chk({12'h0, ta, tb, s3, s4}, {12'h0, ex0(r0)});
                chk({10'h0, io0, q0, io1, q1}, {10'h0, ex2(r2)});
            end
        end
        $display("test routing done");
        // Remaining group codes, prohibited ones included, and status
        wr(`IRS_IDX_ROUTE2, 8'h10);
        tick(4);
        chk({16'h0, io0, io1}, {16'h0, 8'h00, p1_pin});
        rdchk(`IRS_IDX_STATUS, {2'b01, p8[3], p8[1], p8[0],
                                p8[3], p8[1], p8[0]});
        wr(`IRS_IDX_ROUTE2, 8'h20);
        tick(4);
        chk({16'h0, io0, io1}, {16'h0, 8'h00, p4});
        wr(`IRS_IDX_ROUTE2, 8'hF3);
        tick(4);
        chk({16'h0, io0, io1}, 32'h00000000);
        rdchk(`IRS_IDX_STATUS, {2'b11, p8[2], p3[1], p3[0],
                                p8[3], p8[1], p8[0]});
        chk({31'h0, hresp}, 32'h00000000);
        $display("test group codes done");
        d1 <= 8'h01;
        wr(`IRS_IDX_PULLUP, 8'h05);
        tick(3);
        chk({pu5, pu4, pu3, pu1}, 32'h00000F0E);
        d1 <= 8'h00;
        d4 <= 8'h81;
        wr(`IRS_IDX_PULLUP, 8'hF0);
        tick(3);
        chk({pu5, pu4, pu3, pu1}, 32'hFF7E0000);
        $display("test pull-up done");
        d1 <= 8'hFF;
        p1_out <= 8'h0F;
        wr(`IRS_IDX_ODSEL, 8'h01);
        tick(3);
        chk({16'h0, hi_en, lo_en}, 32'h000000F0);
        wr(`IRS_IDX_ODSEL, 8'h00);
        tick(3);
        chk({16'h0, hi_en, lo_en}, 32'h00000FF0);
        $display("test output mode done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
